// [core/audio_serial_port_framing.sv]
// register file, clock generation and data framing of a three-wire audio serial port.
// assumes the bench resolves bclk, wclk and data wires from the enables and feeds the
// resolved bit clock back on bclk_i in both master and slave mode.
//
// Local design decision: strobed register access.

module audio_serial_port_framing
	import audio_port_pkg::*;
(
	input wire logic mclk_i, // system clock, 50 MHz
	input wire logic rstn_i, // asynchronous reset, active low
	input wire logic [7:0] addr_i, // register address
	input wire logic [7:0] wdata_i, // register write data
	input wire logic wr_i, // write strobe
	input wire logic rd_i, // read strobe
	output logic [7:0] rdata_o, // read data, cycle after rd_i
	input wire logic sample_wr_i, // write one channel sample
	input wire logic [1:0] sample_ch_i, // 0=1L 1=1R 2=2L 3=2R
	input wire logic [31:0] sample_data_i, // sample, msb aligned to word length lsb side
	output logic frame_tick_o, // one mclk pulse when samples are taken for a frame
	input wire logic bclk_i, // resolved bit clock, link clock
	output logic bclk_o, // generated bit clock
	output logic bclk_oe_o, // bit clock drive enable
	input wire logic wclk_i, // resolved frame clock
	output logic wclk_o, // generated frame clock
	output logic wclk_oe_o, // frame clock drive enable
	output logic sdo_o, // serial_data_output level
	output logic sdo_oe_o // serial_data_output drive enable
);

	// register file, mclk domain
	logic [7:0] port_format_r; // enable, channel count, word length, format
	logic [7:0] tdm_ctrl_r; // tdm mode, output enable, slot_channel_enables
	logic [7:0] ofs_low_r; // data offset low byte
	logic [2:0] ofs_high_r; // data offset high bits
	logic [7:0] clk_ctrl_r; // master, tri-state, polarities, frame length
	logic [7:0] frames_r; // frames served, readable status
	logic [7:0] rdata_nxt;
	logic [CFG_W-1:0] cfg_vec; // all config, to the link domain

	// sample store and crossing, mclk side
	logic [31:0] sample_mem [4]; // written by the user side
	logic [31:0] hold_mem [4]; // copy handed to the link domain
	logic req_s1_r, req_s2_r, req_s3_r; // frame request toggle synchroniser
	logic ack_tgl_r; // hold copy is ready
	logic [3:0] div_r; // bit clock divider
	logic bclk_r;

	// link domain
	logic lrst_meta_r, lrst_n_r; // link reset release synchroniser
	logic [CFG_W-1:0] cfg_meta_r, cfg_sync_r;
	logic wclk_s1_r, wclk_s2_r; // frame clock synchroniser
	logic ack_s1_r, ack_s2_r, ack_s3_r;
	logic req_tgl_r;
	logic [31:0] word_mem [4]; // samples in use for the current frame
	logic [11:0] bit_cnt_r, bit_cnt_nxt; // bit period index in the frame
	logic [11:0] frame_len_r; // measured frame length, slave
	logic [11:0] gap_r; // bit periods since the last external frame edge
	logic wlev_d_r; // previous frame level
	logic wclk_r, wclk_oe_r, bclk_oe_r;
	logic sdo_pos_r, sdoe_pos_r, sdo_neg_r, sdoe_neg_r;
	logic data_nxt, drive_nxt;

	// unpacked synchronised config
	logic s_port_en, s_tdm, s_oe, s_master, s_tri, s_wpol, s_bpol;
	logic [2:0] s_ch_count;
	logic [1:0] s_wlen, s_bpf;
	format_e s_fmt;
	logic [3:0] s_slot_en;
	logic [10:0] s_ofs;

	// framing helpers
	logic use_ext_wclk, wlev, start_ext, frame_start, in_data;
	logic [11:0] len, half, lead, pos, base;
	logic [5:0] wbits;
	logic [11:0] wbits_x;

	// register writes; frame length and polarities reach the port through the config synchroniser
	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			port_format_r <= RST_PORT_FORMAT;
			tdm_ctrl_r <= RST_TDM_CTRL;
			ofs_low_r <= RST_OFS_LOW;
			ofs_high_r <= RST_OFS_HIGH;
			clk_ctrl_r <= RST_CLK_CTRL;
		end
		else if (wr_i)
		begin
			case (addr_i)
				ADDR_PORT_FORMAT: port_format_r <= wdata_i;
				ADDR_TDM_CTRL: tdm_ctrl_r <= {wdata_i[7:6], 2'b00, wdata_i[3:0]};
				ADDR_OFS_LOW: ofs_low_r <= wdata_i;
				ADDR_OFS_HIGH: ofs_high_r <= wdata_i[2:0];
				ADDR_CLK_CTRL: clk_ctrl_r <= {wdata_i[7], 2'b00, wdata_i[4:0]};
				default: ; // unmapped writes are dropped
			endcase
		end
	end

	// read mux, reserved bits read zero, unmapped reads zero
	always_comb
	begin
		case (addr_i)
			ADDR_PORT_FORMAT: rdata_nxt = port_format_r;
			ADDR_TDM_CTRL: rdata_nxt = tdm_ctrl_r;
			ADDR_OFS_LOW: rdata_nxt = ofs_low_r;
			ADDR_OFS_HIGH: rdata_nxt = {5'h00, ofs_high_r};
			ADDR_CLK_CTRL: rdata_nxt = clk_ctrl_r;
			ADDR_STATUS: rdata_nxt = frames_r;
			default: rdata_nxt = 8'h00;
		endcase
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			rdata_o <= 8'h00;
		else if (rd_i)
			rdata_o <= rdata_nxt;
		else
			rdata_o <= 8'h00;
	end

	// the offset is built from both fields into one 11-bit count
	assign cfg_vec = {port_format_r, tdm_ctrl_r[7:6], tdm_ctrl_r[3:0], ofs_high_r, ofs_low_r,
		clk_ctrl_r[7], clk_ctrl_r[4:0]};

	// user-side sample store
	always_ff @(posedge mclk_i)
	begin
		if (sample_wr_i)
			sample_mem[sample_ch_i] <= sample_data_i;
	end

	// request toggle from the link domain, two flops then an edge detector
	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			req_s1_r <= 1'b0;
			req_s2_r <= 1'b0;
			req_s3_r <= 1'b0;
		end
		else
		begin
			req_s1_r <= req_tgl_r;
			req_s2_r <= req_s1_r;
			req_s3_r <= req_s2_r;
		end
	end

	// copy samples into the hold store; it stays still until the next request,
	// so the link domain may read it once it sees the ack toggle
	always_ff @(posedge mclk_i)
	begin
		if (req_s2_r ^ req_s3_r)
			hold_mem <= sample_mem;
	end

	// ack toggle, frame counter and the frame tick pulse
	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			ack_tgl_r <= 1'b0;
			frames_r <= 8'h00;
			frame_tick_o <= 1'b0;
		end
		else
		begin
			frame_tick_o <= req_s2_r ^ req_s3_r;
			if (req_s2_r ^ req_s3_r)
			begin
				ack_tgl_r <= ~ack_tgl_r;
				frames_r <= frames_r + 8'h01;
			end
		end
	end

	// master bit clock from the system clock; stopped low in slave mode
	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			div_r <= 4'h0;
			bclk_r <= 1'b0;
			bclk_oe_r <= 1'b0;
		end
		else
		begin
			bclk_oe_r <= clk_ctrl_r[MASTER_BIT];
			if (!clk_ctrl_r[MASTER_BIT])
			begin
				div_r <= 4'h0;
				bclk_r <= 1'b0;
			end
			else if (div_r == BCLK_HALF_CYCLES - 4'h1)
			begin
				div_r <= 4'h0;
				bclk_r <= ~bclk_r;
			end
			else
				div_r <= div_r + 4'h1;
		end
	end

	assign bclk_o = bclk_r;
	assign bclk_oe_o = bclk_oe_r;

	// link reset: asserts at once, releases on the bit clock
	always_ff @(posedge bclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			lrst_meta_r <= 1'b0;
			lrst_n_r <= 1'b0;
		end
		else
		begin
			lrst_meta_r <= 1'b1;
			lrst_n_r <= lrst_meta_r;
		end
	end

	// config bits crossed one by one; software must not change them mid-frame,
	// a change is only guaranteed coherent a few bit clocks later
	always_ff @(posedge bclk_i or negedge lrst_n_r)
	begin
		if (!lrst_n_r)
		begin
			cfg_meta_r <= '0;
			cfg_sync_r <= '0;
		end
		else
		begin
			cfg_meta_r <= cfg_vec;
			cfg_sync_r <= cfg_meta_r;
		end
	end

	assign s_port_en = cfg_sync_r[30];
	assign s_ch_count = cfg_sync_r[29:27];
	assign s_wlen = cfg_sync_r[26:25];
	assign s_fmt = format_e'(cfg_sync_r[24:23]);
	assign s_tdm = cfg_sync_r[22];
	assign s_oe = cfg_sync_r[21];
	assign s_slot_en = cfg_sync_r[20:17];
	assign s_ofs = cfg_sync_r[16:6];
	assign s_master = cfg_sync_r[5];
	assign s_tri = cfg_sync_r[4];
	assign s_wpol = cfg_sync_r[3];
	assign s_bpol = cfg_sync_r[2];
	assign s_bpf = cfg_sync_r[1:0];

	// frame clock and ack toggle synchronisers
	always_ff @(posedge bclk_i or negedge lrst_n_r)
	begin
		if (!lrst_n_r)
		begin
			wclk_s1_r <= 1'b0;
			wclk_s2_r <= 1'b0;
			ack_s1_r <= 1'b0;
			ack_s2_r <= 1'b0;
			ack_s3_r <= 1'b0;
		end
		else
		begin
			wclk_s1_r <= wclk_i;
			wclk_s2_r <= wclk_s1_r;
			ack_s1_r <= ack_tgl_r;
			ack_s2_r <= ack_s1_r;
			ack_s3_r <= ack_s2_r;
		end
	end

	// frame clock is an input in slave mode or when forced by the tri-state control
	assign use_ext_wclk = !s_master || s_tri;
	// frame level normalised so a rising edge starts the left channel
	assign wlev = wclk_s2_r ^ s_wpol ^ (s_fmt == FMT_I2S);
	assign start_ext = use_ext_wclk && wlev && !wlev_d_r;
	assign frame_start = use_ext_wclk ? start_ext : (bit_cnt_r == frame_bits(s_bpf) - 12'h001);

	// bit period counter wraps at the frame length, measured in slave mode, so the
	// first bits of a frame go out before its edge has passed the synchroniser
	always_comb
	begin
		if (start_ext)
			bit_cnt_nxt = WCLK_SYNC_LAG;
		else if (bit_cnt_r >= len - 12'h001)
			bit_cnt_nxt = 12'h000;
		else if (bit_cnt_r == CNT_MAX)
			bit_cnt_nxt = CNT_MAX;
		else
			bit_cnt_nxt = bit_cnt_r + 12'h001;
	end

	// counter, measured frame length and the request toggle
	always_ff @(posedge bclk_i or negedge lrst_n_r)
	begin
		if (!lrst_n_r)
		begin
			bit_cnt_r <= 12'h000;
			frame_len_r <= RST_FRAME_LEN;
			gap_r <= 12'h000;
			wlev_d_r <= 1'b1; // idle level after reset, so no false frame edge
			req_tgl_r <= 1'b0;
		end
		else
		begin
			bit_cnt_r <= bit_cnt_nxt;
			wlev_d_r <= wlev;
			// length is the spacing of two detected edges, saturating if none come
			if (start_ext)
			begin
				frame_len_r <= gap_r;
				gap_r <= 12'h001;
			end
			else if (gap_r != CNT_MAX)
				gap_r <= gap_r + 12'h001;
			if (frame_start)
				req_tgl_r <= ~req_tgl_r;
		end
	end

	// new samples take effect once the ack is seen, a few bit clocks after the request
	always_ff @(posedge bclk_i)
	begin
		if (ack_s2_r ^ ack_s3_r)
			word_mem <= hold_mem;
	end

	assign len = use_ext_wclk ? frame_len_r : frame_bits(s_bpf);
	assign half = {1'b0, len[11:1]};
	assign wbits = word_bits(s_wlen);
	assign wbits_x = {6'h00, wbits};
	// i2s starts one bit after the frame edge, then the programmed offset
	assign lead = {11'h000, s_fmt == FMT_I2S} + {1'b0, s_ofs};
	assign in_data = bit_cnt_nxt >= lead;
	assign pos = bit_cnt_nxt - lead;

	// locate the next bit period in a slot and pick the bit to send, msb first
	always_comb
	begin
		data_nxt = 1'b0;
		drive_nxt = 1'b0;
		base = 12'h000;
		for (int k = 0; k < 4; k++)
		begin
			if (s_tdm || s_fmt == FMT_DSP)
				base = wbits_x * 12'(k); // slots packed back to back
			else if (s_fmt == FMT_RIGHT)
				base = (k[0] ? len : half) - wbits_x; // data ends at the half edge, right channel at the frame end
			else
				base = (k[0] ? half : 12'h000) + (k[1] ? wbits_x : 12'h000);
			if (in_data && pos >= base && pos < base + wbits_x
				&& !(s_fmt == FMT_RIGHT && !s_tdm && k[1])
				&& s_port_en && s_ch_count <= CH_COUNT_MAX
				&& 3'(k) < s_ch_count
				&& (!s_tdm || s_slot_en[k]))
			begin
				data_nxt = word_mem[k][5'(wbits_x - 12'h001 - (pos - base))];
				drive_nxt = 1'b1;
			end
		end
		// normal mode keeps the line driven; tdm only drives live slots
		if (!s_tdm)
			drive_nxt = 1'b1;
		if (!s_oe)
			drive_nxt = 1'b0;
	end

	// data launched on the rising bit clock, frame clock built from the next count
	always_ff @(posedge bclk_i or negedge lrst_n_r)
	begin
		if (!lrst_n_r)
		begin
			sdo_pos_r <= 1'b0;
			sdoe_pos_r <= 1'b0;
			wclk_r <= 1'b0;
			wclk_oe_r <= 1'b0;
		end
		else
		begin
			sdo_pos_r <= data_nxt;
			sdoe_pos_r <= drive_nxt;
			wclk_oe_r <= s_master && !s_tri;
			case (s_fmt)
				FMT_I2S: wclk_r <= (bit_cnt_nxt >= half) ^ s_wpol;
				FMT_DSP: wclk_r <= (bit_cnt_nxt == 12'h000) ^ s_wpol;
				default: wclk_r <= (bit_cnt_nxt < half) ^ s_wpol;
			endcase
		end
	end

	// retime onto the falling edge so the far end can sample on the rising one
	always_ff @(negedge bclk_i or negedge lrst_n_r)
	begin
		if (!lrst_n_r)
		begin
			sdo_neg_r <= 1'b0;
			sdoe_neg_r <= 1'b0;
		end
		else
		begin
			sdo_neg_r <= sdo_pos_r;
			sdoe_neg_r <= sdoe_pos_r;
		end
	end

	// inverted bit clock sense: data changes on the rising edge instead
	assign sdo_o = s_bpol ? sdo_pos_r : sdo_neg_r;
	assign sdo_oe_o = s_bpol ? sdoe_pos_r : sdoe_neg_r;
	assign wclk_o = wclk_r;
	assign wclk_oe_o = wclk_oe_r;

endmodule : audio_serial_port_framing

// [core/audio_port_pkg.sv]
// constants, field positions and helper functions of the audio serial port framing block.
// assumes one mclk_i domain for the register port and one bit-clock domain for the link.
package audio_port_pkg;

	// register offsets, byte addresses on the plain register port
	localparam logic [7:0] ADDR_PORT_FORMAT = 8'h8c;
	localparam logic [7:0] ADDR_TDM_CTRL = 8'h8d;
	localparam logic [7:0] ADDR_OFS_LOW = 8'h8e;
	localparam logic [7:0] ADDR_OFS_HIGH = 8'h8f;
	localparam logic [7:0] ADDR_CLK_CTRL = 8'h90;
	localparam logic [7:0] ADDR_STATUS = 8'h91;

	// values after reset
	localparam logic [7:0] RST_PORT_FORMAT = 8'h28;
	localparam logic [7:0] RST_TDM_CTRL = 8'h40;
	localparam logic [7:0] RST_OFS_LOW = 8'h00;
	localparam logic [2:0] RST_OFS_HIGH = 3'h0;
	localparam logic [7:0] RST_CLK_CTRL = 8'h01;
	// slave frame length assumed until the first frame has been measured
	localparam logic [11:0] RST_FRAME_LEN = 12'h040;

	// field positions, port format register
	localparam int PORT_EN_BIT = 7;
	localparam int CH_COUNT_LSB = 4;
	localparam int WORD_LEN_LSB = 2;
	localparam int FORMAT_LSB = 0;
	// field positions, tdm output control register
	localparam int TDM_MODE_BIT = 7;
	localparam int OUT_EN_BIT = 6;
	localparam int SLOT_EN_LSB = 0;
	// field positions, clocking control register
	localparam int MASTER_BIT = 7;
	localparam int WCLK_TRI_BIT = 4;
	localparam int WCLK_POL_BIT = 3;
	localparam int BCLK_POL_BIT = 2;
	localparam int BCLKS_SEL_LSB = 0;

	// synchronised config vector width
	localparam int CFG_W = 31;
	// largest channel-count code that is not reserved
	localparam logic [2:0] CH_COUNT_MAX = 3'h4;
	// mclk cycles per half period of the generated bit clock (12.5 MHz at 50 MHz)
	localparam logic [3:0] BCLK_HALF_CYCLES = 4'h2;
	// frame counters saturate here
	localparam logic [11:0] CNT_MAX = 12'hfff;
	// index loaded when an external frame edge is detected: two sync flops plus the edge flop
	localparam logic [11:0] WCLK_SYNC_LAG = 12'h003;

	// serial data formats
	typedef enum logic [1:0] {
		FMT_I2S = 2'b00,
		FMT_LEFT = 2'b01,
		FMT_RIGHT = 2'b10,
		FMT_DSP = 2'b11
	} format_e;

	// bits per channel for a word-length code
	function automatic logic [5:0] word_bits(input logic [1:0] code);
		case (code)
			2'b00: word_bits = 6'h10;
			2'b01: word_bits = 6'h14;
			2'b10: word_bits = 6'h18;
			default: word_bits = 6'h20;
		endcase
	endfunction : word_bits

	// bit clocks per frame in master mode: 32, 64, 128, 256
	function automatic logic [11:0] frame_bits(input logic [1:0] code);
		frame_bits = 12'h020 << code;
	endfunction : frame_bits

endpackage : audio_port_pkg

// [testbench/audio_serial_port_framing_assertions.sv]
// checker for the audio serial port framing block, bound to its top module.
// assumes a register write has reached the link within 255 system clocks.
module audio_serial_port_framing_checker
	import audio_port_pkg::*;
(
	input wire logic mclk_i,
	input wire logic rstn_i,
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [7:0] rdata_o,
	input wire logic bclk_o,
	input wire logic bclk_oe_o,
	input wire logic wclk_o,
	input wire logic wclk_oe_o,
	input wire logic sdo_o,
	input wire logic sdo_oe_o
);
	logic [7:0] tdm_r; // shadow of tdm output control
	logic [7:0] fmt_r; // shadow of port format
	logic [7:0] clk_r; // shadow of clocking control
	logic [2:0] hi_r; // shadow of offset high field
	logic [7:0] quiet_r; // clocks since last write, saturating
	logic [11:0] fcnt_r; // generated bit clocks in the running frame
	logic [1:0] nfr_r; // frame starts since last write
	logic bq_r; // bit clock one sample ago
	logic wq_r; // frame clock one sample ago
	wire brise = bclk_o && !bq_r;
	wire wrise = wclk_o && !wq_r;
	wire calm = quiet_r == 8'hff; // config crosses on the link clock, so wait
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!rstn_i);
	// shadows follow writes; the first frames after a change may be mixed
	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			{tdm_r, fmt_r, clk_r, hi_r} <= {RST_TDM_CTRL, RST_PORT_FORMAT, RST_CLK_CTRL, RST_OFS_HIGH};
			{quiet_r, fcnt_r, nfr_r, bq_r, wq_r} <= '0;
		end
		else
		begin
			bq_r <= bclk_o;
			wq_r <= wclk_o;
			quiet_r <= wr_i ? 8'h00 : (calm ? quiet_r : quiet_r + 8'h01);
			nfr_r <= wr_i ? 2'h0 : ((wrise && nfr_r != 2'h3) ? nfr_r + 2'h1 : nfr_r);
			fcnt_r <= wrise ? 12'h001 : (brise ? fcnt_r + 12'h001 : fcnt_r);
			if (wr_i && addr_i == ADDR_TDM_CTRL)
				tdm_r <= wdata_i;
			if (wr_i && addr_i == ADDR_PORT_FORMAT)
				fmt_r <= wdata_i;
			if (wr_i && addr_i == ADDR_CLK_CTRL)
				clk_r <= wdata_i;
			if (wr_i && addr_i == ADDR_OFS_HIGH)
				hi_r <= wdata_i[2:0];
		end
	end
	sequence s_rd(logic [7:0] a);
		rd_i && addr_i == a;
	endsequence
	property p_rd_tdm;
		s_rd(ADDR_TDM_CTRL) |=> rdata_o == (tdm_r & 8'hcf);
	endproperty
	a_rd_tdm: assert property (p_rd_tdm) else $error("tdm control read back wrong");
	property p_rd_ofs;
		s_rd(ADDR_OFS_HIGH) |=> rdata_o == {5'h00, hi_r};
	endproperty
	a_rd_ofs: assert property (p_rd_ofs) else $error("offset high read back wrong");
	property p_rd_clk;
		s_rd(ADDR_CLK_CTRL) |=> rdata_o == (clk_r & 8'h9f);
	endproperty
	a_rd_clk: assert property (p_rd_clk) else $error("clock control read back wrong");
	property p_bclk_dir;
		calm |-> bclk_oe_o == clk_r[MASTER_BIT];
	endproperty
	a_bclk_dir: assert property (p_bclk_dir) else $error("bit clock direction wrong");
	property p_wclk_dir;
		calm |-> wclk_oe_o == (clk_r[MASTER_BIT] && !clk_r[WCLK_TRI_BIT]);
	endproperty
	a_wclk_dir: assert property (p_wclk_dir) else $error("frame clock direction wrong");
	property p_oe_off;
		calm && !tdm_r[OUT_EN_BIT] |-> !sdo_oe_o;
	endproperty
	a_oe_off: assert property (p_oe_off) else $error("data driven with output off");
	property p_tdm_idle;
		calm && tdm_r[TDM_MODE_BIT] && tdm_r[3:0] == 4'h0 |-> !sdo_oe_o;
	endproperty
	a_tdm_idle: assert property (p_tdm_idle) else $error("tdm line not released");
	property p_no_data;
		calm && !fmt_r[PORT_EN_BIT] && sdo_oe_o |-> !sdo_o;
	endproperty
	a_no_data: assert property (p_no_data) else $error("data sent while disabled");
	property p_frame_len;
		wrise && nfr_r >= 2'h2 && clk_r[MASTER_BIT] && !clk_r[WCLK_TRI_BIT]
			|-> fcnt_r == (12'h020 << clk_r[1:0]);
	endproperty
	a_frame_len: assert property (p_frame_len) else $error("master frame length wrong");
endmodule : audio_serial_port_framing_checker

bind audio_serial_port_framing audio_serial_port_framing_checker chk (
	.mclk_i, .rstn_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .bclk_o,
	.bclk_oe_o, .wclk_o, .wclk_oe_o, .sdo_o, .sdo_oe_o
);

// [testbench/audio_host_model.sv]
// host audio processor model: supplies i2s clocks of 64 bits per frame, captures frames.
// assumes the bench resolves the shared wires; data is sampled on the rising bit clock.
module audio_host_model
(
	input wire logic drive_bclk_i, // host owns the bit clock
	input wire logic sdo_i, // resolved serial data line
	output logic bclk_o, // host bit clock, still while not owned
	output logic wclk_o, // host frame clock
	output logic [63:0] frame_o // last whole frame, index 0 in the msb
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [5:0] cnt_r = 6'h3f; // bit index within the frame
	logic [63:0] sh_r = 64'h0; // incoming bits
	initial frame_o = 64'h0;
	initial wclk_o = 1'b0;
	// 12 ns clock, phase chosen never to meet a system clock edge
	initial
	begin
		bclk_o = 1'b0;
		#1;
		forever
		begin
			bclk_o = drive_bclk_i ? ~bclk_o : 1'b0;
			#6;
		end
	end
	// frame clock moves on the falling edge: low first half, high second half
	always @(negedge bclk_o)
	begin
		cnt_r <= cnt_r + 6'h01;
		wclk_o <= (cnt_r + 6'h01) >= 6'h20;
	end
	// shift in one bit per rising edge, keep the frame at its last bit
	always @(posedge bclk_o)
	begin
		sh_r <= {sh_r[62:0], sdo_i};
		if (cnt_r == 6'h3f)
			frame_o <= {sh_r[62:0], sdo_i};
	end
endmodule : audio_host_model

// [testbench/audio_serial_port_framing_tb.sv]
// bench for the audio serial port framing block: register tasks, samples, frame checks.
// assumes the host model on the link and the bound checker beside the design.
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin bad_count++; \
	$display("mismatch at %0t: got %0h expected %0h", $time, got, exp); end end
module audio_serial_port_framing_tb
	import audio_port_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk, rstn, wr, rd, swr, flt, hdrv, bo, boe, wo, woe, so, soe, hb, hw, tick;
	logic [7:0] addr, wdata, rdata, ticks; // ticks counts frame tick pulses
	logic [1:0] sch;
	logic [31:0] sdat;
	logic [63:0] rx;
	localparam logic [63:0] D1 = 64'hf0a5c3e1;
	localparam logic [63:0] D2 = 64'h0f5a963c;
	localparam logic [7:0] RA [4] = '{8'h8d, 8'h8e, 8'h8f, 8'h90};
	localparam logic [7:0] RV [4] = '{8'h40, 8'h00, 8'h00, 8'h01};
	localparam logic [7:0] WV [4] = '{8'hff, 8'ha5, 8'hff, 8'h6e};
	localparam logic [7:0] WX [4] = '{8'hcf, 8'ha5, 8'h07, 8'h0e};
	int bad_count = 0;
	int comparisons = 0;
	wire bclk_w = boe ? bo : hb; // device wins once it drives
	wire wclk_w = woe ? wo : hw;
	wire sdo_w = soe ? so : flt; // released line shows a toggling pattern
	audio_serial_port_framing uut (.mclk_i(mclk), .rstn_i(rstn), .addr_i(addr),
		.wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .sample_wr_i(swr),
		.sample_ch_i(sch), .sample_data_i(sdat), .frame_tick_o(tick), .bclk_i(bclk_w),
		.bclk_o(bo), .bclk_oe_o(boe), .wclk_i(wclk_w), .wclk_o(wo), .wclk_oe_o(woe),
		.sdo_o(so), .sdo_oe_o(soe));
	audio_host_model host (.drive_bclk_i(hdrv), .sdo_i(sdo_w), .bclk_o(hb), .wclk_o(hw),
		.frame_o(rx));
	initial
	begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	always @(posedge mclk) flt <= ~flt;
	// the status register must count exactly the tick pulses seen here
	always @(posedge mclk)
		if (tick)
			ticks <= ticks + 8'h01;
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : print_verdict
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		{wr, addr, wdata} <= {1'b1, a, d};
		@(posedge mclk);
		wr <= 1'b0;
	endtask : wr_reg
	// read strobe for one cycle, data looked at in the following cycle only
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		@(posedge mclk);
		{rd, addr} <= {1'b1, a};
		@(posedge mclk);
		rd <= 1'b0;
		@(negedge mclk);
		`CHK(rdata, e)
	endtask : rd_chk
	task automatic load(input logic [1:0] c, input logic [31:0] d);
		@(posedge mclk);
		{swr, sch, sdat} <= {1'b1, c, d};
		@(posedge mclk);
		swr <= 1'b0;
	endtask : load
	task automatic settle(input int n);
		repeat (n) @(posedge mclk);
	endtask : settle
	// slot 0 starts at index lead, slot 1 half a frame later, msb first
	function automatic logic [63:0] exp_frame(input int w, input int lead);
		logic [63:0] m;
		m = (64'h1 << w) - 64'h1;
		exp_frame = ((D1 & m) << (64 - lead - w)) | ((D2 & m) << (32 - lead - w));
	endfunction : exp_frame
	// hang guard, well above the roughly ten thousand clocks the tests need
	initial
	begin
		repeat (30000) @(posedge mclk);
		bad_count++;
		print_verdict();
	end
	initial
	begin
		{wr, rd, swr, flt, addr, wdata, sch, sdat, ticks} = '0;
		hdrv = 1'b1;
		rstn = 1'b0;
		repeat (2) @(posedge mclk);
		rstn <= 1'b1;
		rd_chk(ADDR_PORT_FORMAT, RST_PORT_FORMAT);
		for (int i = 0; i < 4; i++)
		begin
			rd_chk(RA[i], RV[i]);
			wr_reg(RA[i], WV[i]);
			rd_chk(RA[i], WX[i]);
			wr_reg(RA[i], RV[i]);
		end
		wr_reg(8'h00, 8'hff);
		rd_chk(8'h00, 8'h00);
		load(2'h0, D1[31:0]);
		load(2'h1, D2[31:0]);
		for (int wl = 0; wl < 3; wl++)
		begin
			wr_reg(ADDR_PORT_FORMAT, {4'ha, wl[1:0], 2'h0});
			settle(300);
			`CHK(rx, exp_frame(16 + 4 * wl, 1))
		end
		wr_reg(ADDR_OFS_LOW, 8'h05);
		settle(300);
		`CHK(rx, exp_frame(24, 6))
		wr_reg(ADDR_OFS_LOW, 8'h00);
		// inverted frame sense starts the frame at the opposite edge: halves swap
		wr_reg(ADDR_CLK_CTRL, 8'h09);
		settle(300);
		`CHK({rx[31:0], rx[63:32]}, exp_frame(24, 1))
		wr_reg(ADDR_CLK_CTRL, RST_CLK_CTRL);
		wr_reg(ADDR_TDM_CTRL, 8'hc1);
		settle(300);
		`CHK(rx[62:39], D1[23:0])
		wr_reg(ADDR_TDM_CTRL, 8'hc0);
		settle(300);
		`CHK(soe, 1'b0)
		wr_reg(ADDR_TDM_CTRL, 8'h00);
		settle(300);
		`CHK(soe, 1'b0)
		wr_reg(ADDR_TDM_CTRL, 8'h40);
		wr_reg(ADDR_PORT_FORMAT, 8'h28);
		settle(300);
		`CHK(rx, 64'h0)
		// frame counter read in line, so the expected count is taken as the data stands
		@(posedge mclk);
		{rd, addr} <= {1'b1, ADDR_STATUS};
		@(posedge mclk);
		rd <= 1'b0;
		@(negedge mclk);
		`CHK(rdata, ticks)
		for (int c = 0; c < 4; c++)
		begin
			wr_reg(ADDR_CLK_CTRL, {6'h20, c[1:0]});
			settle(20);
			hdrv <= 1'b0;
			settle(12 * (32 << c) + 300);
			`CHK({boe, woe}, 2'b11)
		end
		wr_reg(ADDR_CLK_CTRL, 8'h91);
		settle(300);
		`CHK({boe, woe}, 2'b10)
		print_verdict();
	end
endmodule : audio_serial_port_framing_tb
